// ### dram_state_pkg.sv
/*
  Shared types and constants for the per-bank command state tracker.
  Assumes a single system clock; counts are in memory clock edges.
*/
`default_nettype none

package dram_state_pkg;

  // ****************************************************************
  // Sizes and default thresholds (memory clock edges)
  // ****************************************************************
  localparam int bank_count = 8;
  localparam int bank_bits = 3;
  localparam int count_bits = 8;
  localparam logic [7:0] precharge_period_default = 8'h03;
  localparam logic [7:0] activate_to_access_period_default = 8'h03;
  localparam logic [7:0] single_bank_refresh_period_default = 8'h08;
  localparam logic [7:0] all_bank_refresh_period_default = 8'h10;
  localparam logic [7:0] mode_read_period_default = 8'h04;
  localparam logic [7:0] mode_write_period_default = 8'h0a;
  localparam logic [7:0] self_refresh_exit_period_default = 8'h12;
  localparam logic [7:0] power_down_exit_period_default = 8'h03;
  localparam logic [7:0] burst_period_default = 8'h04;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [count_bits:0] count_t;

  typedef enum logic [2:0] {
    op_idle, op_activate, op_read, op_write,
    op_precharge, op_refresh, op_mode_read, op_mode_write
  } op_t;

  typedef struct packed {
    logic cs_n;
    op_t op;
    logic [bank_bits-1:0] bank;
    logic all_bank;
    logic auto_precharge;
  } ca_t;

  typedef struct packed {
    logic [count_bits-1:0] precharge_period;
    logic [count_bits-1:0] activate_to_access_period;
    logic [count_bits-1:0] single_bank_refresh_period;
    logic [count_bits-1:0] all_bank_refresh_period;
    logic [count_bits-1:0] mode_read_period;
    logic [count_bits-1:0] mode_write_period;
    logic [count_bits-1:0] self_refresh_exit_period;
    logic [count_bits-1:0] power_down_exit_period;
    logic [count_bits-1:0] burst_period;
  } timing_t;

  typedef enum logic [3:0] {
    bank_idle, bank_activating, bank_active, bank_reading, bank_writing,
    bank_read_ap, bank_write_ap, bank_precharging, bank_refreshing
  } bank_state_t;

  typedef enum logic [2:0] {
    dev_power_on, dev_resetting, dev_ready, dev_refresh_all,
    dev_mode_write, dev_mode_read, dev_precharge_all
  } dev_state_t;

  typedef struct packed {
    bank_state_t mode;
    count_t cnt;
  } bank_reg_t;

  // A zero threshold still occupies one edge.
  function automatic count_t period_load(input logic [count_bits-1:0] p);
    return (p == '0) ? count_t'(1) : {1'b0, p};
  endfunction : period_load

endpackage : dram_state_pkg

`default_nettype wire

// ### dram_pin_sync.sv
/*
  Two-stage synchroniser for a bundle of pins.
  Assumes the bundle is stable long enough to be caught together.
*/
`timescale 1ns/1ns
`default_nettype none

module dram_pin_sync #(
  parameter int width = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [width-1:0] din,
  output logic [width-1:0] dout
);

  typedef struct packed {
    logic [width-1:0] first;
    logic [width-1:0] second;
  } sync_t;

  sync_t cur;
  sync_t next_cur;

  // The first stage feeds only the second stage.
  always_comb begin
    next_cur.first = din;
    next_cur.second = cur.first;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign dout = cur.second;

endmodule : dram_pin_sync

`default_nettype wire

// ### dram_bank_tracker.sv
/*
  State and timer of one bank.
  Assumes tick marks a memory clock edge on which commands count and
  hit marks a command addressed to this bank on that edge.
*/
`timescale 1ns/1ns
`default_nettype none

module dram_bank_tracker (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic hit,
  input wire dram_state_pkg::op_t op,
  input wire logic auto_precharge,
  input wire dram_state_pkg::timing_t timing,
  output var dram_state_pkg::bank_state_t state,
  output logic illegal
);
  import dram_state_pkg::*;

  bank_reg_t cur;
  bank_reg_t next_cur;
  bank_state_t eff;
  logic expire;

  // State a timed state falls into once its count runs out.
  function automatic bank_state_t settle(input bank_state_t m);
    unique case (m)
      bank_activating, bank_reading, bank_writing, bank_active: return bank_active;
      default: return bank_idle;
    endcase
  endfunction : settle

  // ****************************************************************
  // Next state
  // ****************************************************************
  // A state whose count ends on this edge is judged as its successor,
  // so a command may follow on the very edge the period is met.
  always_comb begin
    next_cur = cur;
    illegal = 1'b0;
    expire = cur.cnt <= count_t'(1);
    eff = expire ? settle(cur.mode) : cur.mode;
    if (tick) begin
      if (expire) begin
        next_cur.mode = eff;
        next_cur.cnt = '0;
      end else begin
        next_cur.cnt = cur.cnt - count_t'(1);
      end
      if (hit) begin
        unique case (eff)
          bank_idle: begin
            if (op == op_activate) begin
              next_cur.mode = bank_activating;
              next_cur.cnt = period_load(timing.activate_to_access_period);
            end else if (op == op_refresh) begin
              next_cur.mode = bank_refreshing;
              next_cur.cnt = period_load(timing.single_bank_refresh_period);
            end else if (op == op_precharge) begin
              next_cur.mode = bank_precharging;
              next_cur.cnt = period_load(timing.precharge_period);
            end else begin
              illegal = 1'b1;
            end
          end
          bank_active, bank_reading, bank_writing: begin
            // A running burst accepts only a burst of its own kind.
            if ((eff == bank_reading && op != op_read) ||
                (eff == bank_writing && op != op_write)) begin
              illegal = 1'b1;
            end else if (op == op_read || op == op_write) begin
              if (auto_precharge) begin
                next_cur.mode = (op == op_read) ? bank_read_ap : bank_write_ap;
                next_cur.cnt = count_t'(period_load(timing.burst_period) +
                                        period_load(timing.precharge_period));
              end else begin
                next_cur.mode = (op == op_read) ? bank_reading : bank_writing;
                next_cur.cnt = period_load(timing.burst_period);
              end
            end else if (op == op_precharge) begin
              next_cur.mode = bank_precharging;
              next_cur.cnt = period_load(timing.precharge_period);
            end else begin
              illegal = 1'b1;
            end
          end
          default: illegal = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur <= '{mode: bank_idle, cnt: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign state = cur.mode;

  // ****************************************************************
  // Checks
  // ****************************************************************
  activate_start_a: assert property (
    @(posedge clk) disable iff (reset)
    tick && hit && op == op_activate && cur.mode == bank_idle |=> state == bank_activating)
    else $error("activate did not open the row timer");
  activate_end_a: assert property (
    @(posedge clk) disable iff (reset)
    tick && !hit && cur.mode == bank_activating && cur.cnt == count_t'(1)
    |=> state == bank_active)
    else $error("row activating did not end in active");
  precharge_idle_a: assert property (
    @(posedge clk) disable iff (reset)
    tick && hit && op == op_precharge && cur.mode == bank_idle |=> state == bank_precharging)
    else $error("precharge of idle bank skipped its period");
  precharge_end_a: assert property (
    @(posedge clk) disable iff (reset)
    tick && !hit && cur.mode == bank_precharging && cur.cnt == count_t'(1)
    |=> state == bank_idle)
    else $error("precharging did not end in idle");
  busy_bank_a: assert property (
    @(posedge clk) disable iff (reset)
    tick && hit && cur.cnt > count_t'(1) &&
    cur.mode inside {bank_activating, bank_precharging, bank_read_ap, bank_write_ap}
    |-> illegal)
    else $error("command to busy bank not flagged");
  auto_precharge_end_a: assert property (
    @(posedge clk) disable iff (reset)
    tick && !hit && cur.mode inside {bank_read_ap, bank_write_ap} && cur.cnt == count_t'(1)
    |=> state == bank_idle)
    else $error("auto precharge burst did not end idle");
  bank_refresh_a: assert property (
    @(posedge clk) disable iff (reset)
    tick && hit && op == op_refresh && cur.mode == bank_idle
    |=> state == bank_refreshing ##1 (state == bank_refreshing || state == bank_idle))
    else $error("bank refresh sequence broken");
  write_after_read_a: assert property (
    @(posedge clk) disable iff (reset)
    tick && hit && op == op_write && cur.mode == bank_reading && cur.cnt > count_t'(1)
    |-> illegal ##1 state == bank_reading)
    else $error("write during read burst not refused");

endmodule : dram_bank_tracker

`default_nettype wire

// ### dram_bank_command_state.sv
/*
  Device-wide command state and eight bank trackers for a low-power DDR
  memory. Pins from the controller arrive in another clock domain and
  are synchronised; memory clock edges are found by sampling mem_ck.
  Thresholds come from logic on clk and are held steady in use.
*/
`timescale 1ns/1ns
`default_nettype none

module dram_bank_command_state (
  input wire logic clk,
  input wire logic reset,
  input wire logic mem_ck,
  input wire logic cke,
  input wire dram_state_pkg::ca_t ca,
  input wire dram_state_pkg::timing_t timing,
  output var dram_state_pkg::bank_state_t [dram_state_pkg::bank_count-1:0] bank_state,
  output var dram_state_pkg::dev_state_t device_state,
  output logic illegal_command,
  output logic rules_active
);
  import dram_state_pkg::*;

  localparam int pin_width = 2 + $bits(ca_t);

  typedef struct packed {
    logic ck_last;
    logic cke_last;
    count_t exit_cnt;
    dev_state_t dev;
    dev_state_t saved;
    count_t cnt;
    logic illegal;
    logic active;
  } main_t;

  main_t cur;
  main_t next_cur;
  logic [pin_width-1:0] pins_sync;
  logic s_ck;
  logic s_cke;
  ca_t s_ca;
  logic edge_seen;
  logic rules_on;
  logic tick;
  logic cmd;
  logic all_idle;
  logic burst_busy;
  logic dev_expire;
  dev_state_t dev_eff;
  logic dev_illegal;
  logic [bank_count-1:0] bank_hit;
  logic [bank_count-1:0] bank_illegal;

  // States in which only idle commands are accepted.
  function automatic logic is_quiet(input dev_state_t d);
    return d inside {dev_refresh_all, dev_mode_write, dev_mode_read, dev_precharge_all};
  endfunction : is_quiet

  // ****************************************************************
  // Pin capture
  // ****************************************************************
  // All pins share one synchroniser so that they keep step; the command
  // is taken two system cycles after the memory clock edge, which
  // is harmless because the link clock is far slower than clk.
  dram_pin_sync #(
    .width(pin_width)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .din({mem_ck, cke, ca}),
    .dout(pins_sync)
  );

  assign s_ck = pins_sync[pin_width-1];
  assign s_cke = pins_sync[pin_width-2];
  assign s_ca = ca_t'(pins_sync[pin_width-3:0]);

  // ****************************************************************
  // Edge detection and gating
  // ****************************************************************
  // Commands count only on an edge with clock enable high now and at the
  // previous edge, and once any exit period has run down.
  always_comb begin
    edge_seen = s_ck && !cur.ck_last;
    rules_on = cur.cke_last && s_cke && cur.exit_cnt == '0;
    tick = edge_seen && rules_on;
    cmd = tick && !s_ca.cs_n && s_ca.op != op_idle;
  end

  // Bank summaries used by the device-wide checks.
  always_comb begin
    all_idle = 1'b1;
    burst_busy = 1'b0;
    for (int i = 0; i < bank_count; i++) begin
      if (bank_state[i] != bank_idle) begin
        all_idle = 1'b0;
      end
      if (bank_state[i] inside {bank_reading, bank_writing, bank_read_ap,
                                bank_write_ap, bank_refreshing}) begin
        burst_busy = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Device state
  // ****************************************************************
  // A quiet state whose count ends on this edge is judged as the state
  // it returns to; a mode read returns to whatever it interrupted.
  always_comb begin
    next_cur = cur;
    dev_illegal = 1'b0;
    bank_hit = '0;
    next_cur.ck_last = s_ck;
    dev_expire = cur.cnt <= count_t'(1);
    dev_eff = cur.dev;
    if (is_quiet(cur.dev) && dev_expire) begin
      dev_eff = (cur.dev == dev_mode_read) ? cur.saved : dev_ready;
    end
    // Exit timer: loaded when clock enable rises, then runs down.
    if (edge_seen) begin
      next_cur.cke_last = s_cke;
      next_cur.active = rules_on;
      if (!cur.cke_last && s_cke) begin
        next_cur.exit_cnt = all_idle ? period_load(timing.self_refresh_exit_period) :
                                       period_load(timing.power_down_exit_period);
      end else if (cur.exit_cnt != '0) begin
        next_cur.exit_cnt = cur.exit_cnt - count_t'(1);
      end
    end
    if (tick) begin
      next_cur.dev = dev_eff;
      next_cur.cnt = dev_expire ? '0 : cur.cnt - count_t'(1);
    end
    if (cmd) begin
      unique case (dev_eff)
        dev_power_on: begin
          if (s_ca.op == op_mode_write) begin
            next_cur.dev = dev_resetting;
          end else begin
            dev_illegal = 1'b1;
          end
        end
        dev_resetting: begin
          if (s_ca.op == op_mode_read) begin
            next_cur.saved = dev_resetting;
            next_cur.dev = dev_mode_read;
            next_cur.cnt = period_load(timing.mode_read_period);
          end else if (s_ca.op == op_mode_write) begin
            next_cur.dev = dev_mode_write;
            next_cur.cnt = period_load(timing.mode_write_period);
          end else begin
            dev_illegal = 1'b1;
          end
        end
        dev_ready: begin
          unique case (s_ca.op)
            op_refresh: begin
              if (!s_ca.all_bank) begin
                bank_hit[s_ca.bank] = 1'b1;
              end else if (all_idle) begin
                next_cur.dev = dev_refresh_all;
                next_cur.cnt = period_load(timing.all_bank_refresh_period);
              end else begin
                dev_illegal = 1'b1;
              end
            end
            op_mode_write: begin
              if (all_idle) begin
                next_cur.dev = dev_mode_write;
                next_cur.cnt = period_load(timing.mode_write_period);
              end else begin
                dev_illegal = 1'b1;
              end
            end
            op_mode_read: begin
              if (burst_busy) begin
                dev_illegal = 1'b1;
              end else begin
                next_cur.saved = dev_ready;
                next_cur.dev = dev_mode_read;
                next_cur.cnt = period_load(timing.mode_read_period);
              end
            end
            op_precharge: begin
              if (s_ca.all_bank) begin
                bank_hit = '1;
                next_cur.dev = dev_precharge_all;
                next_cur.cnt = period_load(timing.precharge_period);
              end else begin
                bank_hit[s_ca.bank] = 1'b1;
              end
            end
            default: bank_hit[s_ca.bank] = 1'b1;
          endcase
        end
        default: dev_illegal = 1'b1;
      endcase
    end
    // The flag is a one-cycle pulse per offending command.
    next_cur.illegal = cmd && (dev_illegal || (|bank_illegal));
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur <= '{ck_last: 1'b0, cke_last: 1'b0, exit_cnt: '0, dev: dev_power_on,
               saved: dev_power_on, cnt: '0, illegal: 1'b0, active: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************************
  // Banks
  // ****************************************************************
  for (genvar i = 0; i < bank_count; i++) begin : g_bank
    dram_bank_tracker u_bank (
      .clk(clk),
      .reset(reset),
      .tick(tick),
      .hit(bank_hit[i]),
      .op(s_ca.op),
      .auto_precharge(s_ca.auto_precharge),
      .timing(timing),
      .state(bank_state[i]),
      .illegal(bank_illegal[i])
    );
  end

  assign device_state = cur.dev;
  assign illegal_command = cur.illegal;
  assign rules_active = cur.active;

  // ****************************************************************
  // Checks
  // ****************************************************************
  reset_entry_a: assert property (
    @(posedge clk) disable iff (reset)
    cmd && dev_eff == dev_power_on && s_ca.op == op_mode_write
    |=> device_state == dev_resetting)
    else $error("mode write did not start resetting");
  quiet_flag_a: assert property (
    @(posedge clk) disable iff (reset)
    cmd && is_quiet(cur.dev) && !dev_expire |=> illegal_command ##1 !illegal_command)
    else $error("command in quiet state not flagged once");
  refresh_all_a: assert property (
    @(posedge clk) disable iff (reset)
    cmd && dev_eff == dev_ready && s_ca.op == op_refresh && s_ca.all_bank && all_idle
    |=> device_state == dev_refresh_all && !illegal_command)
    else $error("all-bank refresh not entered");
  wide_busy_a: assert property (
    @(posedge clk) disable iff (reset)
    cmd && dev_eff == dev_ready && s_ca.op == op_mode_write && !all_idle
    |=> illegal_command && device_state == dev_ready)
    else $error("mode write with busy banks accepted");
  mode_write_end_a: assert property (
    @(posedge clk) disable iff (reset)
    tick && !cmd && cur.dev == dev_mode_write && cur.cnt == count_t'(1)
    |=> device_state == dev_ready)
    else $error("mode write did not return to idle");
  mode_read_back_a: assert property (
    @(posedge clk) disable iff (reset)
    tick && !cmd && cur.dev == dev_mode_read && cur.cnt == count_t'(1)
    |=> device_state == $past(cur.saved))
    else $error("mode read did not return to prior state");
  precharge_all_a: assert property (
    @(posedge clk) disable iff (reset)
    cmd && dev_eff == dev_ready && s_ca.op == op_precharge && s_ca.all_bank && all_idle
    |=> device_state == dev_precharge_all && bank_state[0] == bank_precharging)
    else $error("precharge-all did not start");
  gated_rules_a: assert property (
    @(posedge clk) disable iff (reset)
    !(edge_seen && cur.cke_last && s_cke && cur.exit_cnt == '0) |=> !illegal_command)
    else $error("flag raised outside checked edges");

endmodule : dram_bank_command_state

`default_nettype wire

// ### mc_model.sv
/*
  Memory controller model: drives mem_ck, cke and the command pins.
  Assumes the bench calls send once for each command edge.
*/
`timescale 1ns/1ns
`default_nettype none

module mc_model (
  input wire logic clk,
  output logic mem_ck,
  output logic cke,
  output var dram_state_pkg::ca_t ca
);
  import dram_state_pkg::*;

  // ****************************************
  // Pins at rest
  // ****************************************
  // Clock enable never drops, so every edge after the first two is a checked one.
  initial begin
    mem_ck = 1'b0;
    cke = 1'b1;
    ca = '1;
  end

  // One 160 ns memory clock period per command, pins held well past the edge.
  // The clock stops between commands; a released bus shows toggled bits.
  task automatic send(input ca_t c);
    @(posedge clk) ca <= c;
    repeat (4) @(posedge clk);
    mem_ck <= 1'b1;
    repeat (10) @(posedge clk);
    mem_ck <= 1'b0;
    repeat (2) @(posedge clk);
    ca <= {1'b1, ~c[7:0]};
    repeat (3) @(posedge clk);
  endtask : send
endmodule : mc_model

`default_nettype wire

// ### dram_bank_command_state_tb.sv
/*
  Self-checking bench for the bank command state tracker.
  Assumes thresholds of two edges and exit periods of one edge.
*/
`timescale 1ns/1ns
`default_nettype none

module dram_bank_command_state_tb;
  import dram_state_pkg::*;
  logic clk, reset, mem_ck, cke, illegal_command, rules_active;
  ca_t ca;
  timing_t timing;
  bank_state_t [bank_count-1:0] bank_state;
  dev_state_t device_state;
  int n_fail = 0;
  int checks_done = 0;
  int n_ill = 0;
  logic [31:0] seed;
  logic [2:0] b;

  // ****************************************
  // Clock, instances and helpers
  // ****************************************
  // Free running system clock, 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  mc_model ctrl (.clk(clk), .mem_ck(mem_ck), .cke(cke), .ca(ca));
  dram_bank_command_state uut (.clk(clk), .reset(reset), .mem_ck(mem_ck), .cke(cke),
    .ca(ca), .timing(timing), .bank_state(bank_state), .device_state(device_state),
    .illegal_command(illegal_command), .rules_active(rules_active));

  // The flag stands one cycle only, so it is counted on every edge.
  always @(posedge clk) if (illegal_command === 1'b1) n_ill <= n_ill + 1;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ****************************************
  // Reference model
  // ****************************************
  // Bank b and the device with two-edge periods; the other banks stay
  // idle or precharge along with it, so bank b alone decides whether all banks are idle.
  int n_edge = 0;
  int rb_left = 0;
  int rd_left = 0;
  bank_state_t rb = bank_idle;
  dev_state_t rd = dev_power_on;
  dev_state_t rd_back = dev_power_on;
  int ill_q[$];

  // A command for bank b from the ready device; a refused one is queued.
  task automatic ref_bank(input op_t o, input logic ap);
    if (rb == bank_idle && o inside {op_activate, op_refresh, op_precharge}) begin
      rb = (o == op_activate) ? bank_activating :
           (o == op_refresh) ? bank_refreshing : bank_precharging;
      rb_left = 2;
    end else if (rb == bank_active && o == op_precharge) begin
      rb = bank_precharging;
      rb_left = 2;
    end else if ((rb == bank_active && o inside {op_read, op_write}) ||
                 (rb == bank_reading && o == op_read) ||
                 (rb == bank_writing && o == op_write)) begin
      rb = (o == op_read) ? (ap ? bank_read_ap : bank_reading) :
           (ap ? bank_write_ap : bank_writing);
      // Auto precharge holds the bank for the burst plus the precharge.
      rb_left = ap ? 4 : 2;
    end else begin
      ill_q.push_back(n_edge);
    end
  endtask : ref_bank

  // Timers run down first, so a period ending on this edge frees it.
  task automatic ref_step(input op_t o, input logic every_bank, input logic ap);
    n_edge++;
    if (n_edge > 2) begin
      if (rb_left > 0) begin
        rb_left--;
        if (rb_left == 0) begin
          rb = (rb inside {bank_activating, bank_reading, bank_writing}) ?
               bank_active : bank_idle;
        end
      end
      if (rd_left > 0) begin
        rd_left--;
        if (rd_left == 0) begin
          rd = (rd == dev_mode_read) ? rd_back : dev_ready;
        end
      end
      if (o != op_idle) begin
        if (rd == dev_power_on && o == op_mode_write) begin
          rd = dev_resetting;
        end else if (rd == dev_resetting && o inside {op_mode_read, op_mode_write}) begin
          rd_back = rd;
          rd = (o == op_mode_read) ? dev_mode_read : dev_mode_write;
          rd_left = 2;
        end else if (rd != dev_ready) begin
          ill_q.push_back(n_edge);
        end else if (o == op_mode_read && !(rb inside {bank_reading, bank_writing,
                     bank_read_ap, bank_write_ap, bank_refreshing})) begin
          rd_back = rd;
          rd = dev_mode_read;
          rd_left = 2;
        end else if ((o == op_mode_write || (o == op_refresh && every_bank)) &&
                     rb == bank_idle) begin
          rd = (o == op_mode_write) ? dev_mode_write : dev_refresh_all;
          rd_left = 2;
        end else if (o inside {op_mode_read, op_mode_write} ||
                     (o == op_refresh && every_bank)) begin
          ill_q.push_back(n_edge);
        end else begin
          if (o == op_precharge && every_bank) begin
            rd = dev_precharge_all;
            rd_left = 2;
          end
          ref_bank(o, ap);
        end
      end
    end
    chk(8'(bank_state[b]), 8'(rb));
    chk(8'(device_state), 8'(rd));
    chk(8'(n_ill), 8'(ill_q.size()));
  endtask : ref_step

  task automatic go(input op_t o, input logic ap);
    ctrl.send({1'b0, o, b, 1'b0, ap});
    ref_step(o, 1'b0, ap);
  endtask : go

  task automatic go_all(input op_t o);
    ctrl.send({1'b0, o, b, 1'b1, 1'b0});
    ref_step(o, 1'b1, 1'b0);
  endtask : go_all

  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Scenarios
  // ****************************************
  // Expected states follow from two-edge thresholds, counted per command edge.
  initial begin
    reset = 1'b1;
    timing = {8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h01, 8'h01, 8'h02};
    seed = xs(32'h00001d09);
    b = seed[2:0];
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    chk(8'(bank_state[b]), 8'(bank_idle));
    chk(8'(device_state), 8'(dev_power_on));
    repeat (4) go(op_idle, 1'b0);
    chk(8'(rules_active), 8'h01);
    go(op_mode_write, 1'b0);
    chk(8'(device_state), 8'(dev_resetting));
    go(op_mode_write, 1'b0);
    chk(8'(device_state), 8'(dev_mode_write));
    repeat (2) go(op_idle, 1'b0);
    chk(8'(device_state), 8'(dev_ready));
    go(op_activate, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_activating));
    go(op_idle, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_activating));
    go(op_read, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_reading));
    go(op_write, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_reading));
    chk(8'(n_ill), 8'h01);
    go(op_idle, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_active));
    go(op_precharge, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_precharging));
    go(op_activate, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_precharging));
    go(op_idle, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_idle));
    go(op_precharge, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_precharging));
    repeat (2) go(op_idle, 1'b0);
    go(op_activate, 1'b0);
    go(op_idle, 1'b0);
    go(op_read, 1'b1);
    chk(8'(bank_state[b]), 8'(bank_read_ap));
    repeat (3) go(op_idle, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_read_ap));
    go(op_idle, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_idle));
    chk(8'(n_ill), 8'h02);
    // Write bursts, per-bank refresh and the device-wide commands.
    go(op_activate, 1'b0);
    go(op_idle, 1'b0);
    go(op_write, 1'b0);
    go(op_read, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_writing));
    go(op_idle, 1'b0);
    go(op_write, 1'b1);
    go(op_activate, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_write_ap));
    repeat (3) go(op_idle, 1'b0);
    go(op_refresh, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_refreshing));
    repeat (2) go(op_idle, 1'b0);
    go(op_mode_read, 1'b0);
    go(op_activate, 1'b0);
    chk(8'(device_state), 8'(dev_mode_read));
    go(op_idle, 1'b0);
    chk(8'(device_state), 8'(dev_ready));
    go_all(op_refresh);
    chk(8'(device_state), 8'(dev_refresh_all));
    repeat (2) go(op_idle, 1'b0);
    go_all(op_precharge);
    chk(8'(bank_state[b]), 8'(bank_precharging));
    repeat (2) go(op_idle, 1'b0);
    go(op_activate, 1'b0);
    go(op_idle, 1'b0);
    go(op_mode_write, 1'b0);
    chk(8'(n_ill), 8'h06);
    go(op_precharge, 1'b0);
    repeat (2) go(op_idle, 1'b0);
    chk(8'(bank_state[b]), 8'(bank_idle));
    report_and_stop;
  end

  // A hang is cut short well after the expected 1100 cycles.
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
endmodule : dram_bank_command_state_tb

`default_nettype wire
